//--- bench/e1_status_latch_and_irq_tb.sv
// Self-checking bench for the E1 status latch and interrupt block.
`timescale 1ns/1ns
module e1_status_latch_and_irq_tb;
   logic                    clk_in = 1'b0;
   logic                    rst_n_in = 1'b0;
   e1si_pkg::e1si_bus_req_t bus;
   e1si_pkg::e1si_pri_t     pri = '0;
   e1si_pkg::e1si_sec_t     sec = '0;
   e1si_pkg::e1si_rxi_t     rxi = '0;
   e1si_pkg::e1si_sync_t    syn = '0;
   logic [7:0]              rdat, v, a, b;
   logic                    rval, irq_n, ok;
   logic [5:0]              cnt = 6'h00;
   logic [3:0]              once_l [5] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'ha};
   logic [3:0]              rep_l [7] =
      '{4'h4, 4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
   int                      err_total = 0;
   int                      n_checks = 0;

   initial begin
      forever #2 clk_in = ~clk_in;
   end

   e1si_status_irq dut_u (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .bus_req_in   (bus),
      .pri_cond_in  (pri),
      .sec_cond_in  (sec),
      .rxi_cond_in  (rxi),
      .sync_cond_in (syn),
      .rd_data_out  (rdat),
      .rd_valid_out (rval),
      .irq_n_out    (irq_n)
   );

   e1si_host_model host_u (
      .clk_in      (clk_in),
      .rd_data_in  (rdat),
      .rd_valid_in (rval),
      .bus_req_out (bus)
   );

   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
      host_u.rd(ad, v, ok);
      chk("valid", {7'h00, ok}, 8'h01);
      chk($sformatf("reg %h", ad), v, e);
   endtask

   task automatic clrc(input logic [7:0] ad, input logic [7:0] m,
                       input logic [7:0] e);
      host_u.clr(ad, m, v, ok);
      chk("valid", {7'h00, ok}, 8'h01);
      chk($sformatf("reg %h", ad), v, e);
   endtask

   // Four cycles cover the two-stage path from condition to pin.
   task automatic irq_is(input logic e);
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      chk("irq_n", {7'h00, irq_n}, {7'h00, e});
   endtask

   // Bit 3 of the selector picks the secondary conditions.
   task automatic drive(input logic [3:0] s, input logic on);
      @(posedge clk_in);
      pri <= (!s[3] && on) ? 8'h01 << s[2:0] : 8'h00;
      sec <= (s[3] && on) ? 8'h01 << s[2:0] : 8'h00;
      a = s[3] ? e1si_pkg::SEC_ADDR : e1si_pkg::PRI_ADDR;
      b = 8'h01 << s[2:0];
   endtask

   task automatic cnt_up(input int n);
      @(posedge clk_in);
      syn.crc_search_timeout <= 1'b1;
      repeat (n) @(posedge clk_in);
      syn.crc_search_timeout <= 1'b0;
      cnt = cnt + n[5:0];
   endtask

   function automatic logic [7:0] sview(input logic [5:0] c,
                                        input logic [2:0] act);
      return {c[5:2], c[0], act};
   endfunction

   task automatic summarize();
      if (err_total == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      summarize();
   end

   initial begin
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      irq_is(1'b1);
      for (int k = 0; k < e1si_pkg::NUM_LATCH; k++) begin
         clrc(e1si_pkg::REG_ADDR[k], 8'hff, 8'h00);
      end
      rdc(8'h33, 8'h00);
      rdc(e1si_pkg::PRI_MASK_ADDR, 8'h00);
      host_u.wr(e1si_pkg::PRI_MASK_ADDR, 8'hff);
      host_u.wr(e1si_pkg::SEC_MASK_ADDR, 8'hff);
      rdc(e1si_pkg::SEC_MASK_ADDR, 8'hff);
      for (int i = 0; i < 4; i++) begin
         drive(i[3:0], 1'b1);
         irq_is(1'b0);
         clrc(a, b, b);
         irq_is(1'b1);
         clrc(a, b, b);
         drive(i[3:0], 1'b0);
         irq_is(1'b0);
         host_u.clr(a, b, v, ok);
         irq_is(1'b1);
         clrc(a, b, 8'h00);
      end
      drive(4'h4, 1'b1);
      drive(4'h4, 1'b0);
      irq_is(1'b0);
      clrc(a, 8'h00, 8'h00);
      irq_is(1'b0);
      clrc(a, b, b);
      irq_is(1'b1);
      clrc(a, b, 8'h00);
      host_u.wr(e1si_pkg::PRI_MASK_ADDR, 8'hef);
      drive(4'h4, 1'b1);
      drive(4'h4, 1'b0);
      irq_is(1'b1);
      clrc(a, b, b);
      host_u.wr(e1si_pkg::PRI_MASK_ADDR, 8'hff);
      foreach (once_l[k]) begin
         drive(once_l[k], 1'b1);
         irq_is(1'b0);
         clrc(a, b, b);
         irq_is(1'b1);
         drive(once_l[k], 1'b0);
         if (k == 3) begin
            drive(once_l[k], 1'b1);
            irq_is(1'b0);
            host_u.clr(a, b, v, ok);
            drive(once_l[k], 1'b0);
         end
      end
      foreach (rep_l[k]) begin
         drive(rep_l[k], 1'b1);
         irq_is(1'b0);
         clrc(a, b, b);
         irq_is(1'b0);
         drive(rep_l[k], 1'b0);
         host_u.clr(a, b, v, ok);
         irq_is(1'b1);
      end
      for (int c = 0; c < 4; c++) begin
         @(posedge clk_in);
         rxi <= {c[1:0], 6'h00};
         clrc(e1si_pkg::RXI_ADDR, 8'hc0, {c[1:0], 6'h00});
      end
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_in);
         rxi <= 8'h01 << i;
         @(posedge clk_in);
         rxi <= 8'h00;
         // Bits 7:6 are masked out here, so they keep the last level code.
         clrc(e1si_pkg::RXI_ADDR, 8'h3f,
              8'hc0 | (8'h01 << i));
      end
      irq_is(1'b1);
      @(posedge clk_in);
      syn.crc_mode_enable <= 1'b1;
      cnt_up(43);
      rdc(e1si_pkg::SYNC_ADDR, sview(cnt, 3'h0));
      cnt_up(22);
      rdc(e1si_pkg::SYNC_ADDR, sview(cnt, 3'h0));
      host_u.wr(e1si_pkg::SYNC_ADDR, 8'hff);
      rdc(e1si_pkg::SYNC_ADDR, sview(cnt, 3'h0));
      @(posedge clk_in);
      syn.crc_sync_found <= 1'b1;
      @(posedge clk_in);
      syn.crc_sync_found <= 1'b0;
      cnt = 6'h00;
      rdc(e1si_pkg::SYNC_ADDR, 8'h00);
      cnt_up(5);
      rdc(e1si_pkg::SYNC_ADDR, sview(cnt, 3'h0));
      @(posedge clk_in);
      syn.crc_mode_enable <= 1'b0;
      rdc(e1si_pkg::SYNC_ADDR, 8'h00);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_in);
         {syn.align_search_active, syn.sig_mf_search_active,
          syn.crc_mf_search_active} <= i[2:0];
         rdc(e1si_pkg::SYNC_ADDR, sview(6'h00, i[2:0]));
      end
      summarize();
   end
endmodule

//--- bench/e1si_host_model.sv
// Host processor model that drives the control port of the status block.
`timescale 1ns/1ns
module e1si_host_model (
   input  wire logic               clk_in,
   input  wire logic [7:0]         rd_data_in,
   input  wire logic               rd_valid_in,
   output e1si_pkg::e1si_bus_req_t bus_req_out
);
   initial bus_req_out = '0;

   // A released bus shows the inverse of its last address and data, so a
   // design that samples it outside a strobe cannot reuse a stale request.
   task automatic drop();
      bus_req_out <= '{1'b0, 1'b0, ~bus_req_out.addr, ~bus_req_out.wdata};
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      bus_req_out <= '{1'b1, 1'b0, a, d};
      @(posedge clk_in);
      drop();
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v,
                     output logic ok);
      @(posedge clk_in);
      bus_req_out <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_in);
      drop();
      ok = 1'b0;
      for (int i = 0; i < 3 && !ok; i++) begin
         @(negedge clk_in);
         ok = (rd_valid_in === 1'b1);
      end
      v = rd_data_in;
   endtask

   // The write-back clears only what the first write refreshed and software
   // has seen set, since events arrive unrelated to host accesses.
   task automatic clr(input logic [7:0] a, input logic [7:0] m,
                      output logic [7:0] v, output logic ok);
      wr(a, m);
      rd(a, v, ok);
      wr(a, v & m);
   endtask
endmodule

//--- logic/e1si_crc_search_count.sv
// Six-bit counter of CRC multiframe search timeouts.
`timescale 1ns/1ns
module e1si_crc_search_count (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       timeout_in,
   input  wire logic       sync_found_in,
   input  wire logic       mode_enable_in,
   output logic [5:0]      count_out
);

   logic [5:0] count_q;

   // Clearing wins over a timeout in the same cycle; overflow wraps.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         count_q <= e1si_pkg::COUNT_RST;
      end else if (sync_found_in || !mode_enable_in) begin
         count_q <= e1si_pkg::COUNT_RST;
      end else if (timeout_in) begin
         count_q <= count_q + e1si_pkg::COUNT_STEP;
      end
   end

   assign count_out = count_q;

   a_count_clear: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (sync_found_in || !mode_enable_in) |=> (count_q == 6'h00))
      else $error("search counter not cleared");

   a_count_step: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (timeout_in && !sync_found_in && mode_enable_in)
      |=> (count_q == $past(count_q) + 6'h01))
      else $error("search counter did not advance by one");

endmodule

//--- logic/e1si_pkg.sv
// Package with addresses, bit masks, reset values and carrier types.
package e1si_pkg;

   // Register addresses on the parallel control port.
   localparam logic [7:0] RXI_ADDR      = 8'h08;
   localparam logic [7:0] SYNC_ADDR     = 8'h09;
   localparam logic [7:0] PRI_ADDR      = 8'h0a;
   localparam logic [7:0] SEC_ADDR      = 8'h0b;
   localparam logic [7:0] PRI_MASK_ADDR = 8'h18;
   localparam logic [7:0] SEC_MASK_ADDR = 8'h19;

   // Reset values.
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] MASK_RST   = 8'h00;
   localparam logic [7:0] READ_NONE  = 8'h00;
   localparam logic [5:0] COUNT_RST  = 6'h00;
   localparam logic [5:0] COUNT_STEP = 6'h01;

   // Latched registers in generate order: primary, secondary, rx info.
   localparam int NUM_LATCH = 3;
   localparam int NUM_IRQ   = 2;
   localparam logic [7:0] REG_ADDR [NUM_LATCH] =
      '{PRI_ADDR, SEC_ADDR, RXI_ADDR};
   // Bits that latch only on the rising edge of their condition.
   localparam logic [7:0] ONCE_M  [NUM_LATCH] = '{8'he0, 8'h05, 8'h00};
   // Alarm bits: interrupt on every change, stay set while present.
   localparam logic [7:0] ALARM_M [NUM_LATCH] = '{8'h0f, 8'h00, 8'h00};
   // Bits that always carry the present value of their input.
   localparam logic [7:0] LIVE_M  [NUM_LATCH] = '{8'h00, 8'h00, 8'hc0};

   // Sync search status field positions.
   localparam int SYNC_CNT_HI  = 7;
   localparam int SYNC_CNT_LO  = 4;
   localparam int SYNC_CNT_B0  = 3;

   // Register bus request from the host, same clock as the block.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } e1si_bus_req_t;

   // Primary status conditions, bit 7 down to bit 0.
   typedef struct packed {
      logic ts16_ones_event;
      logic distant_mf_alarm;
      logic ts16_zeros_event;
      logic slip_event;
      logic unframed_ones_alarm;
      logic far_end_alarm;
      logic carrier_loss_alarm;
      logic sync_loss_alarm;
   } e1si_pri_t;

   // Secondary status conditions, bit 7 down to bit 0.
   typedef struct packed {
      logic rx_multiframe_tick;
      logic rx_align_frame_tick;
      logic tx_multiframe_tick;
      logic one_hz_tick;
      logic tx_align_frame_tick;
      logic tx_clock_loss;
      logic rx_crc_multiframe_tick;
      logic pattern_lock_detect;
   } e1si_sec_t;

   // Receive information conditions, bit 7 down to bit 0.
   typedef struct packed {
      logic rx_level_code_hi;
      logic rx_level_code_lo;
      logic jitter_fifo_near_limit;
      logic slip_buffer_full;
      logic slip_buffer_empty;
      logic crc_resync_needed;
      logic align_word_resync_needed;
      logic sig_mf_resync_needed;
   } e1si_rxi_t;

   // Synchronizer state and counter controls.
   typedef struct packed {
      logic crc_search_timeout;
      logic crc_sync_found;
      logic crc_mode_enable;
      logic align_search_active;
      logic sig_mf_search_active;
      logic crc_mf_search_active;
   } e1si_sync_t;

endpackage

//--- logic/e1si_status_irq.sv
// Latched status registers, sync search status and interrupt output.
`timescale 1ns/1ns
// What this block does
// - Events set latched bits until software writes 1.
// - Write 1 clears bit; present alarms stay set.
// - Write bits 1 refresh view; 0 hold.
// - Sync search status is live, read-only.
// - Status latches individually masked; others never interrupt.
// - Mask bit 0 blocks, 1 enables interrupt.
// - Alarm interrupt on every alarm state change.
// - Writing 1 to alarm bit releases interrupt despite alarm.
// - Event interrupts, released when 1 written to event bit.
// - Repeating events interrupt on every occurrence.
// - One-shot events interrupt once per onset.
// - Receive level code in rx info bits 7:6.
// - Jitter near-limit flag at rx info bit 5.
// - Slip buffer full and empty flags latched.
// - CRC resync-needed flag at bit 2.
// - Align-word resync-needed flag at bit 1.
// - Signalling multiframe resync-needed flag at bit 0.
// - Search counter bits 5..2,0 in status 7..3.
// - Status bits 2..0 show search activity.
// - Counter counts timeouts, clears on sync, wraps.
module e1si_status_irq (
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire e1si_pkg::e1si_bus_req_t bus_req_in,
   input  wire e1si_pkg::e1si_pri_t     pri_cond_in,
   input  wire e1si_pkg::e1si_sec_t     sec_cond_in,
   input  wire e1si_pkg::e1si_rxi_t     rxi_cond_in,
   input  wire e1si_pkg::e1si_sync_t    sync_cond_in,
   output logic [7:0]                   rd_data_out,
   output logic                         rd_valid_out,
   output logic                         irq_n_out
);

   // Compares a bus address with one register address.
   function automatic logic addr_hit(input logic [7:0] addr,
                                     input logic [7:0] target);
      addr_hit = (addr == target);
   endfunction

   // Bits that set this cycle: edge for one-shot bits, level otherwise.
   function automatic logic [7:0] set_vec(input logic [7:0] cur,
                                          input logic [7:0] prev,
                                          input logic [7:0] once);
      set_vec = (once & cur & ~prev) | (~once & cur);
   endfunction

   logic [7:0] cond    [e1si_pkg::NUM_LATCH];
   logic [7:0] prev_q  [e1si_pkg::NUM_LATCH];
   logic [7:0] latch_q [e1si_pkg::NUM_LATCH];
   logic [7:0] view_q  [e1si_pkg::NUM_LATCH];
   logic [7:0] wmask   [e1si_pkg::NUM_LATCH];
   logic [7:0] pend_q  [e1si_pkg::NUM_IRQ];
   logic [7:0] pri_mask_q;
   logic [7:0] sec_mask_q;
   logic [7:0] rd_data_q;
   logic       rd_valid_q;
   logic       irq_n_q;
   logic       irq_any;
   logic [5:0] crc_count;
   logic [7:0] sync_view;

   assign cond[0] = pri_cond_in;
   assign cond[1] = sec_cond_in;
   assign cond[2] = rxi_cond_in;

   // Each latched register keeps two copies. The latch collects events
   // all the time; the view is what the host reads, and only a write
   // moves latch contents into it. Events arriving between the host's
   // write and read therefore never corrupt the value being polled.
   genvar g;
   generate
      for (g = 0; g < e1si_pkg::NUM_LATCH; g++) begin : g_latch
         logic [7:0] set_now;
         logic [7:0] keep;
         logic [7:0] cur;
         logic [7:0] live;
         logic       hit_w;

         always_comb begin
            live    = e1si_pkg::LIVE_M[g];
            hit_w   = bus_req_in.wr
                      && addr_hit(bus_req_in.addr, e1si_pkg::REG_ADDR[g]);
            wmask[g] = hit_w ? bus_req_in.wdata : 8'h00;
            set_now = set_vec(cond[g], prev_q[g],
                              e1si_pkg::ONCE_M[g]);
            // Alarm and live bits fall back to the present condition
            // when cleared, so a standing alarm stays visible.
            keep    = (e1si_pkg::ALARM_M[g] | live) & cond[g];
            cur     = ((latch_q[g] | set_now) & ~live)
                      | (cond[g] & live);
         end

         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               prev_q[g] <= e1si_pkg::STATUS_RST;
            end else begin
               prev_q[g] <= cond[g];
            end
         end

         // Clearing is per bit and the set term is ORed in after the
         // clear, so an event in the clearing cycle survives.
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               latch_q[g] <= e1si_pkg::STATUS_RST;
            end else begin
               latch_q[g] <= ((((latch_q[g] & ~wmask[g]) | set_now
                              | (wmask[g] & keep)) & ~live)
                              | (cond[g] & live));
            end
         end

         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               view_q[g] <= e1si_pkg::STATUS_RST;
            end else begin
               view_q[g] <= (view_q[g] & ~wmask[g])
                            | (wmask[g] & cur);
            end
         end

         // Only the two status latches own interrupt pending bits.
         if (g < e1si_pkg::NUM_IRQ) begin : g_pend
            logic [7:0] pend_set;

            always_comb begin
               pend_set = (e1si_pkg::ALARM_M[g] & (cond[g] ^ prev_q[g]))
                          | (~e1si_pkg::ALARM_M[g] & set_now);
            end

            // A transfer of the bit to the view releases its pending
            // interrupt, whether or not the alarm is still present.
            always_ff @(posedge clk_in) begin
               if (!rst_n_in) begin
                  pend_q[g] <= e1si_pkg::STATUS_RST;
               end else begin
                  pend_q[g] <= (pend_q[g] & ~wmask[g])
                               | pend_set;
               end
            end
         end
      end
   endgenerate

   // Interrupt mask registers.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pri_mask_q <= e1si_pkg::MASK_RST;
      end else if (bus_req_in.wr
                   && addr_hit(bus_req_in.addr,
                               e1si_pkg::PRI_MASK_ADDR)) begin
         pri_mask_q <= bus_req_in.wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sec_mask_q <= e1si_pkg::MASK_RST;
      end else if (bus_req_in.wr
                   && addr_hit(bus_req_in.addr,
                               e1si_pkg::SEC_MASK_ADDR)) begin
         sec_mask_q <= bus_req_in.wdata;
      end
   end

   // The rx info latch has no pending bits, so it can never interrupt.
   assign irq_any = |((pend_q[0] & pri_mask_q)
                      | (pend_q[1] & sec_mask_q));

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= ~irq_any;
      end
   end

   e1si_crc_search_count u_count (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .timeout_in     (sync_cond_in.crc_search_timeout),
      .sync_found_in  (sync_cond_in.crc_sync_found),
      .mode_enable_in (sync_cond_in.crc_mode_enable),
      .count_out      (crc_count)
   );

   // Counter bit 1 is not brought out.
   assign sync_view = {crc_count[5:2], crc_count[0],
                       sync_cond_in.align_search_active,
                       sync_cond_in.sig_mf_search_active,
                       sync_cond_in.crc_mf_search_active};

   // Reads have no side effects; clearing is done by the mask write.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_data_q <= e1si_pkg::READ_NONE;
      end else if (bus_req_in.rd) begin
         case (bus_req_in.addr)
            e1si_pkg::PRI_ADDR:      rd_data_q <= view_q[0];
            e1si_pkg::SEC_ADDR:      rd_data_q <= view_q[1];
            e1si_pkg::RXI_ADDR:      rd_data_q <= view_q[2];
            e1si_pkg::SYNC_ADDR:     rd_data_q <= sync_view;
            e1si_pkg::PRI_MASK_ADDR: rd_data_q <= pri_mask_q;
            e1si_pkg::SEC_MASK_ADDR: rd_data_q <= sec_mask_q;
            default:                 rd_data_q <= e1si_pkg::READ_NONE;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= bus_req_in.rd;
      end
   end

   assign rd_data_out  = rd_data_q;
   assign rd_valid_out = rd_valid_q;
   assign irq_n_out    = irq_n_q;

   a_irq_idle_high: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      !irq_any |=> irq_n_q)
      else $error("interrupt low with nothing pending");

   a_reset_quiet: assert property (@(posedge clk_in)
      !rst_n_in |=> (irq_n_q && !rd_valid_q
                     && view_q[0] == 8'h00 && view_q[1] == 8'h00
                     && view_q[2] == 8'h00))
      else $error("state not cleared by reset");

   a_masked_quiet: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (pri_mask_q == 8'h00 && sec_mask_q == 8'h00) [*2] |-> irq_n_q)
      else $error("interrupt low while all masks are zero");

   a_unmasked_fires: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (((pend_q[0] & pri_mask_q) | (pend_q[1] & sec_mask_q)) != 8'h00)
      |=> !irq_n_q)
      else $error("unmasked pending bit left interrupt high");

   a_alarm_change: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (|((cond[0] ^ prev_q[0]) & 8'h0f & pri_mask_q)
       && !(bus_req_in.wr && bus_req_in.addr == 8'h18))
      |-> ##2 !irq_n_q)
      else $error("alarm change did not pull interrupt low");

   // A standing alarm must not keep the interrupt pending once refreshed.
   a_alarm_release: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      ((wmask[0] & 8'h0f & ~(cond[0] ^ prev_q[0])) != 8'h00)
      |=> ((pend_q[0] & $past(wmask[0] & 8'h0f
                               & ~(cond[0] ^ prev_q[0]))) == 8'h00))
      else $error("alarm pending bit kept after mask write");

   a_event_pend: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      cond[0][4] |=> pend_q[0][4])
      else $error("slip event did not set pending bit");

   a_once_held: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (wmask[1][0] && cond[1][0] && prev_q[1][0])
      |=> (!latch_q[1][0] && !pend_q[1][0]))
      else $error("held one-shot bit latched again");

   a_alarm_stays: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      1'b1 |=> (($past(cond[0]) & 8'h0f & ~latch_q[0]) == 8'h00))
      else $error("present alarm not held in latch");

   a_latch_sticky: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (wmask[0] == 8'h00) |=> ((~latch_q[0] & $past(latch_q[0])) == 8'h00))
      else $error("latched bit dropped without a mask write");

   a_view_hold: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      1'b1 |=> (((view_q[1] ^ $past(view_q[1])) & ~$past(wmask[1]))
                == 8'h00))
      else $error("view bit changed where mask was zero");

   a_jitter_view: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      wmask[2][5] |=> (view_q[2][5] == ($past(latch_q[2][5])
                                         || $past(cond[2][5]))))
      else $error("jitter flag not refreshed by mask write");

   a_level_live: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      1'b1 |=> (latch_q[2][7:6] == $past(cond[2][7:6])))
      else $error("level code not following input");

   a_set_wins: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (wmask[1][7] && cond[1][7]) |=> latch_q[1][7])
      else $error("event lost in clearing cycle");

   a_sync_read: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (bus_req_in.rd && bus_req_in.addr == 8'h09)
      |=> (rd_valid_q && rd_data_q[2:0] == $past(sync_view[2:0])))
      else $error("sync status read mismatch");

   a_count_view: assert property (@(posedge clk_in)
      disable iff (!rst_n_in)
      (bus_req_in.rd && bus_req_in.addr == 8'h09)
      |=> (rd_data_q[7:3] == {$past(crc_count[5:2]),
                              $past(crc_count[0])}))
      else $error("search counter placed wrongly in sync status");

endmodule
